/* card_model.sv */
// Model of the inserted card, watching its clock contact.
// Assumes the core clock sees every level of the card clock.
`timescale 1ns/10ps
module card_model (
    input wire core_clk,
    input wire card_clock_pin,
    output reg [15:0] rise_count = 16'h0000,
    output reg [15:0] last_period = 16'h0000
);
    reg [15:0] since_rise = 16'h0000;
    reg last_level = 1'b0;
    // Period in core cycles between rising edges, so the bench can tell sources apart.
    always @(posedge core_clk) begin
        last_level <= card_clock_pin;
        since_rise <= since_rise + 16'h0001;
        if (card_clock_pin && !last_level) begin
            rise_count <= rise_count + 16'h0001;
            last_period <= since_rise + 16'h0001;
            since_rise <= 16'h0000;
        end
    end
endmodule // card_model

/* slot5_cfg_defs.vh */
// Constants for the slot five configuration and status registers.
// Assumes a byte-wide register port and a 100 MHz core clock.
`ifndef SLOT5_CFG_DEFS_VH
`define SLOT5_CFG_DEFS_VH

// Register selects on the register port.
`define SLOT5_SEL_VOLTAGE 1'b0
`define SLOT5_SEL_RSTCLK 1'b1

// Voltage config and status fields.
`define VCS_IRQ_BIT 7
`define VCS_GOOD_BIT 6
`define VCS_ATR_ERR_BIT 5
`define VCS_FAULT_BIT 2
`define VCS_CLASS_MSB 1
`define VCS_CLASS_LSB 0
`define VCS_RESET 8'h00

// Supply class codes.
`define CLASS_OFF 2'h0
`define CLASS_C_1V8 2'h1
`define CLASS_B_3V 2'h2
`define CLASS_A_5V 2'h3

// Reset and clock control fields.
`define RCC_ART_BIT 7
`define RCC_RST_BIT 5
`define RCC_LEVEL_BIT 4
`define RCC_HALT_BIT 3
`define RCC_SRC_MSB 2
`define RCC_SRC_LSB 0
`define RCC_RESET 8'h08

// Clock source codes.
`define SRC_SYS 3'h0
`define SRC_CONV 3'h1
`define SRC_CONV_DIV2 3'h2
`define SRC_CONV_DIV4 3'h3
`define SRC_AUX 3'h4
`define SRC_AUX_DIV2 3'h5
`define SRC_SYS_DIV2 3'h6
`define SRC_SYS_DIV4 3'h7

// Number of sampled clock sources.
`define NUM_CLK_SRC 3
`endif

/* slot5_cfg_sva.sv */
// Checker for the slot five register block, bound to its top ports.
// Assumes the card clock sources run slower than half the core clock.
`timescale 1ns/10ps
module slot5_cfg_sva (
    input wire core_clk,
    input wire reset,
    input wire reg_sel,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire clock_counter_overflow,
    input wire card_activated,
    input wire card_reset_pin,
    input wire card_clock_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    reg [7:0] ctl_reg;
    reg [5:0] halt_age_reg;
    // Shadow of the control register; the age tells how long a halt has stood.
    always @(posedge core_clk) begin
        if (reset || (reg_wr && reg_sel)) begin
            ctl_reg <= reset ? 8'h08 : reg_wdata;
            halt_age_reg <= 6'h00;
        end else if (ctl_reg[3] && halt_age_reg != 6'h3F) begin
            halt_age_reg <= halt_age_reg + 6'h01;
        end
    end
    property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid misplaced");
    property p_reserved;
        reg_rvalid |-> (reg_rdata & ($past(reg_sel) ? 8'h40 : 8'h18)) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_off_good;
        reg_rvalid && !$past(reg_sel) && reg_rdata[1:0] == 2'h0 |-> !reg_rdata[6];
    endproperty
    a_off_good: assert property (p_off_good) else $error("good with no class");
    property p_rst_manual; !ctl_reg[7] |=> card_reset_pin == $past(ctl_reg[5]); endproperty
    a_rst_manual: assert property (p_rst_manual) else $error("reset pin wrong");
    property p_rst_auto;
        ctl_reg[7] |=> card_reset_pin == ($past(ctl_reg[5]) && $past(card_activated));
    endproperty
    a_rst_auto: assert property (p_rst_auto) else $error("auto reset pin wrong");
    property p_halt; halt_age_reg == 6'h3F |-> card_clock_pin == ctl_reg[4]; endproperty
    a_halt: assert property (p_halt) else $error("halted level wrong");
    property p_no_glitch; $changed(card_clock_pin) |=> $stable(card_clock_pin); endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("clock glitch");
    property p_flag;
        (clock_counter_overflow || (reg_wr && !reg_sel && reg_wdata[5])) ##1
            !(reg_rd && !reg_sel) ##1 (reg_rd && !reg_sel) |=> reg_rdata[5];
    endproperty
    a_flag: assert property (p_flag) else $error("error flag not set");
    c_irq: cover property (reg_rvalid && reg_rdata[7]);
    c_auto: cover property (ctl_reg[7] && card_reset_pin);
    c_halt_high: cover property (halt_age_reg == 6'h3F && card_clock_pin);
endmodule // slot5_cfg_sva
bind smartcard_slot5_cfg_regs slot5_cfg_sva u_sva (.core_clk, .reset, .reg_sel, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .clock_counter_overflow, .card_activated,
    .card_reset_pin, .card_clock_pin);

/* smartcard_slot5_cfg_regs.v */
// Configuration and status logic for smart card slot five: supply class,
// error flags, card reset pin and glitch-free card clock selection.
// Assumes the register port and the event inputs are on core_clk; the
// clock sources and the regulator status come from outside and are synced.
//
// Functional notes
// - Voltage irq flag sets on good-status rise, clears on host read.
// - Answer-reset error sets on clock counter overflow; software may set.
// - Voltage fault sets when supply leaves class range; software may set.
// - With auto transition, reset pin is the bit gated by activation; else the bit.
// - Reset bit set drives reset pin high, under auto transition once activated; clear drives it low.
// - Clock level bit gives the stopped card clock level.
// - Halt holds clock at the level bit; otherwise it runs from source.
// - Eight source codes; host halts clock before crossing aux codes.
// - Source and halt changes reach the clock pin without glitches.
`timescale 1ns/10ps
`include "slot5_cfg_defs.vh"

module smartcard_slot5_cfg_regs (
    input wire core_clk,
    input wire reset,
    input wire reg_sel,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire regulator_in_range,
    input wire clock_counter_overflow,
    input wire card_activated,
    input wire system_clock_input,
    input wire converter_clock,
    input wire auxiliary_clock_input,
    output reg card_reset_pin,
    output reg card_clock_pin
);

    // Picks the card clock level for one configuration from the source set.
    function clk_value;
        input halt;
        input level;
        input [2:0] sel;
        input [7:0] srcs;
        begin
            if (halt) begin
                clk_value = level;
            end else begin
                clk_value = srcs[sel];
            end
        end
    endfunction

    // Decides whether a pending card clock setting may take over this cycle.
    // A stopped side shows a static level, so joining it at an equal level can
    // never shorten a phase. Two running sources must also wait for an edge of
    // the new one, so the first level it puts on the pin is a full half period.
    // Two stopped settings swap at once, which is how software clocking works.
    function adopt_ok;
        input old_halt;
        input new_halt;
        input old_value;
        input new_value_in;
        input new_edge_in;
        begin
            if (old_halt && new_halt) begin
                adopt_ok = 1'b1;
            end else if (old_value != new_value_in) begin
                adopt_ok = 1'b0;
            end else if (old_halt || new_halt) begin
                adopt_ok = 1'b1;
            end else begin
                adopt_ok = new_edge_in;
            end
        end
    endfunction

    // Register fields.
    reg [1:0] supply_class_select_reg;
    reg slot_voltage_irq_flag_reg;
    reg answer_reset_overflow_err_reg;
    reg slot_voltage_fault_reg;
    reg auto_reset_transition_reg;
    reg card_reset_level_bit_reg;
    reg card_clock_level_bit_reg;
    reg card_clock_halt_reg;
    reg [2:0] card_clock_source_select_reg;

    // Regulator status synchroniser and edge history.
    reg range_meta_reg;
    reg range_sync_reg;
    reg good_prev_reg;
    wire slot_voltage_good;
    wire good_rise;
    wire range_lost;

    // Configuration that currently drives the card clock.
    reg active_halt_reg;
    reg active_level_reg;
    reg [2:0] active_src_reg;

    wire wr_voltage;
    wire wr_rstclk;
    wire rd_voltage;
    wire [7:0] src_levels;
    wire [`NUM_CLK_SRC-1:0] raw_clks;
    wire [`NUM_CLK_SRC-1:0] clk_div1;
    wire [`NUM_CLK_SRC-1:0] clk_div2;
    wire [`NUM_CLK_SRC-1:0] clk_div4;
    wire cur_value;
    wire new_value;
    wire new_edge;
    wire take_new;
    reg [7:0] src_prev_reg;

    assign wr_voltage = reg_wr && (reg_sel == `SLOT5_SEL_VOLTAGE);
    assign wr_rstclk = reg_wr && (reg_sel == `SLOT5_SEL_RSTCLK);
    assign rd_voltage = reg_rd && (reg_sel == `SLOT5_SEL_VOLTAGE);

    // Regulator status passes two flip-flops before any logic sees it.
    always @(posedge core_clk) begin
        if (reset) begin
            range_meta_reg <= 1'b0;
            range_sync_reg <= 1'b0;
            good_prev_reg <= 1'b0;
        end else begin
            range_meta_reg <= regulator_in_range;
            range_sync_reg <= range_meta_reg;
            good_prev_reg <= slot_voltage_good;
        end
    end

    // An off class has no range, so good status stays low then.
    assign slot_voltage_good = range_sync_reg && (supply_class_select_reg != `CLASS_OFF);
    assign good_rise = slot_voltage_good && !good_prev_reg;
    assign range_lost = good_prev_reg && !range_sync_reg && (supply_class_select_reg != `CLASS_OFF);

    // Voltage register. Hardware set beats the clear-on-read in one cycle,
    // so an event landing on the read is kept for the next read.
    always @(posedge core_clk) begin
        if (reset) begin
            supply_class_select_reg <= `CLASS_OFF;
            slot_voltage_irq_flag_reg <= 1'b0;
            answer_reset_overflow_err_reg <= 1'b0;
            slot_voltage_fault_reg <= 1'b0;
        end else begin
            if (wr_voltage) begin
                supply_class_select_reg <= reg_wdata[`VCS_CLASS_MSB:`VCS_CLASS_LSB];
            end
            if (good_rise) begin
                slot_voltage_irq_flag_reg <= 1'b1;
            end else if (rd_voltage) begin
                slot_voltage_irq_flag_reg <= 1'b0;
            end
            if (clock_counter_overflow) begin
                answer_reset_overflow_err_reg <= 1'b1;
            end else if (wr_voltage && reg_wdata[`VCS_ATR_ERR_BIT]) begin
                answer_reset_overflow_err_reg <= 1'b1;
            end else if (rd_voltage) begin
                answer_reset_overflow_err_reg <= 1'b0;
            end
            if (range_lost) begin
                slot_voltage_fault_reg <= 1'b1;
            end else if (wr_voltage && reg_wdata[`VCS_FAULT_BIT]) begin
                slot_voltage_fault_reg <= 1'b1;
            end else if (rd_voltage) begin
                slot_voltage_fault_reg <= 1'b0;
            end
        end
    end

    // Reset and clock control register; bit 6 is dropped on write.
    always @(posedge core_clk) begin
        if (reset) begin
            auto_reset_transition_reg <= 1'b0;
            card_reset_level_bit_reg <= 1'b0;
            card_clock_level_bit_reg <= 1'b0;
            card_clock_halt_reg <= 1'b1;
            card_clock_source_select_reg <= `SRC_SYS;
        end else if (wr_rstclk) begin
            auto_reset_transition_reg <= reg_wdata[`RCC_ART_BIT];
            card_reset_level_bit_reg <= reg_wdata[`RCC_RST_BIT];
            card_clock_level_bit_reg <= reg_wdata[`RCC_LEVEL_BIT];
            card_clock_halt_reg <= reg_wdata[`RCC_HALT_BIT];
            card_clock_source_select_reg <= reg_wdata[`RCC_SRC_MSB:`RCC_SRC_LSB];
        end
    end

    // Read data is registered one cycle after the strobe.
    // Reserved bits read as zero.
    always @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd && (reg_sel == `SLOT5_SEL_VOLTAGE)) begin
                reg_rdata <= {slot_voltage_irq_flag_reg, slot_voltage_good,
                              answer_reset_overflow_err_reg, 2'h0,
                              slot_voltage_fault_reg, supply_class_select_reg};
            end else if (reg_rd) begin
                reg_rdata <= {auto_reset_transition_reg, 1'b0,
                              card_reset_level_bit_reg, card_clock_level_bit_reg,
                              card_clock_halt_reg, card_clock_source_select_reg};
            end
        end
    end

    // Card reset pin: with auto transition it rises once activation is done.
    always @(posedge core_clk) begin
        if (reset) begin
            card_reset_pin <= 1'b0;
        end else if (auto_reset_transition_reg) begin
            card_reset_pin <= card_reset_level_bit_reg && card_activated;
        end else begin
            card_reset_pin <= card_reset_level_bit_reg;
        end
    end

    assign raw_clks = {auxiliary_clock_input, converter_clock, system_clock_input};

    // Each source is synchronised and divided by two and four. Dividing
    // after sampling keeps every derived clock on core_clk edges only.
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CLK_SRC; gi = gi + 1) begin : g_src
            reg meta_reg;
            reg sync_reg;
            reg prev_reg;
            reg div2_reg;
            reg div2_prev_reg;
            reg div4_reg;
            always @(posedge core_clk) begin
                if (reset) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    prev_reg <= 1'b0;
                    div2_reg <= 1'b0;
                    div2_prev_reg <= 1'b0;
                    div4_reg <= 1'b0;
                end else begin
                    meta_reg <= raw_clks[gi];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                    div2_prev_reg <= div2_reg;
                    if (sync_reg && !prev_reg) begin
                        div2_reg <= !div2_reg;
                    end
                    if (div2_reg && !div2_prev_reg) begin
                        div4_reg <= !div4_reg;
                    end
                end
            end
            assign clk_div1[gi] = sync_reg;
            assign clk_div2[gi] = div2_reg;
            assign clk_div4[gi] = div4_reg;
        end
    endgenerate

    // Source table indexed by the select code.
    assign src_levels = {clk_div4[0], clk_div2[0], clk_div2[2], clk_div1[2],
                         clk_div4[1], clk_div2[1], clk_div1[1], clk_div1[0]};

    assign cur_value = clk_value(active_halt_reg, active_level_reg, active_src_reg, src_levels);
    assign new_value = clk_value(card_clock_halt_reg, card_clock_level_bit_reg,
                                 card_clock_source_select_reg, src_levels);

    // Last cycle's source levels, so that a fresh edge of the selected source
    // can be told apart from a level that has stood for a while.
    always @(posedge core_clk) begin
        if (reset) begin
            src_prev_reg <= 8'h00;
        end else begin
            src_prev_reg <= src_levels;
        end
    end

    // The new source has just changed level, so it will hold it for a half period.
    assign new_edge = src_levels[card_clock_source_select_reg] !=
                      src_prev_reg[card_clock_source_select_reg];
    assign take_new = adopt_ok(active_halt_reg, card_clock_halt_reg, cur_value, new_value,
                               new_edge);

    // A new setting is taken only when the switch cannot leave a short level on
    // the pin; the cost is up to about a period of the slower source in delay.
    always @(posedge core_clk) begin
        if (reset) begin
            active_halt_reg <= 1'b1;
            active_level_reg <= 1'b0;
            active_src_reg <= `SRC_SYS;
            card_clock_pin <= 1'b0;
        end else if (take_new) begin
            active_halt_reg <= card_clock_halt_reg;
            active_level_reg <= card_clock_level_bit_reg;
            active_src_reg <= card_clock_source_select_reg;
            card_clock_pin <= new_value;
        end else begin
            card_clock_pin <= cur_value;
        end
    end

endmodule // smartcard_slot5_cfg_regs

/* testbench.sv */
// Bench for the slot five block: flags, reset pin, card clock sources.
// Assumes source clock edges never meet a rising core clock edge.
`timescale 1ns/10ps
module testbench;
    reg core_clk = 1'b0, reset = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg in_range = 1'b0, ovf = 1'b0, act = 1'b0, sys_clk = 1'b0, conv_clk = 1'b0;
    reg aux_clk = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire [15:0] rises, period;
    wire rvalid, rst_pin, ck_pin;
    integer fail_count = 0, tests_run = 0, i;
    localparam [63:0] per_table = {8'h18, 8'h0C, 8'h20, 8'h10, 8'h20, 8'h10, 8'h08, 8'h06};
    // Source edges fall on whole tens of ns, core edges on fives, so sampling is exact.
    always #5 core_clk = ~core_clk;
    always #30 sys_clk = ~sys_clk;
    always #40 conv_clk = ~conv_clk;
    always #80 aux_clk = ~aux_clk;
    smartcard_slot5_cfg_regs u_dut (.core_clk(core_clk), .reset(reset), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(rvalid), .regulator_in_range(in_range), .clock_counter_overflow(ovf),
        .card_activated(act), .system_clock_input(sys_clk), .converter_clock(conv_clk),
        .auxiliary_clock_input(aux_clk), .card_reset_pin(rst_pin), .card_clock_pin(ck_pin));
    card_model u_card (.core_clk(core_clk), .card_clock_pin(ck_pin), .rise_count(rises),
        .last_period(period));
    task check(input [7:0] g, input [7:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (fail_count == 0 && tests_run > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    // Requests start just after an edge and hold until the edge that takes them.
    task wr(input s, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_sel <= s;
            reg_wr <= 1'b1;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input s, input [7:0] e);
        begin
            @(posedge core_clk);
            reg_sel <= s;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1;
            check({7'h00, rvalid}, 8'h01);
            check(reg_rdata, e);
        end
    endtask
    task pins(input integer n, input [7:0] e);
        begin
            repeat (n) @(posedge core_clk);
            #1;
            check({6'h00, rst_pin, ck_pin}, e);
        end
    endtask
    task wait_rises(input integer n);
        integer k;
        reg [15:0] start;
        begin
            start = rises;
            for (k = 0; rises - start < n; k = k + 1) begin
                if (k == 400) begin
                    fail_count = fail_count + 1;
                    report_and_stop;
                end
                @(posedge core_clk);
            end
        end
    endtask
    task t_flags;
        begin
            rd(1'b0, 8'h00);
            rd(1'b1, 8'h08);
            @(posedge core_clk);
            in_range <= 1'b1;
            wr(1'b0, 8'h01);
            repeat (8) @(posedge core_clk);
            rd(1'b0, 8'hC1);
            rd(1'b0, 8'h41);
            for (i = 2; i < 4; i = i + 1) begin
                wr(1'b0, i[7:0]);
                repeat (8) @(posedge core_clk);
                rd(1'b0, 8'h40 | i[7:0]);
            end
            @(posedge core_clk);
            in_range <= 1'b0;
            repeat (8) @(posedge core_clk);
            rd(1'b0, 8'h07);
            rd(1'b0, 8'h03);
            wr(1'b0, 8'h24);
            rd(1'b0, 8'h24);
            @(posedge core_clk);
            ovf <= 1'b1;
            @(posedge core_clk);
            ovf <= 1'b0;
            rd(1'b0, 8'h20);
            @(posedge core_clk);
            in_range <= 1'b1;
            repeat (8) @(posedge core_clk);
            rd(1'b0, 8'h00);
        end
    endtask
    task t_pins;
        begin
            wr(1'b1, 8'h28);
            pins(2, 8'h02);
            wr(1'b1, 8'hA8);
            pins(2, 8'h00);
            @(posedge core_clk);
            act <= 1'b1;
            pins(3, 8'h02);
            wr(1'b1, 8'h58);
            rd(1'b1, 8'h18);
            pins(70, 8'h01);
            wr(1'b1, 8'h08);
            pins(70, 8'h00);
        end
    endtask
    // Halt, switch source while halted, then run, as the aux codes demand.
    task t_sources;
        reg [7:0] prev;
        begin
            prev = 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                wr(1'b1, 8'h08 | prev);
                repeat (70) @(posedge core_clk);
                wr(1'b1, 8'h08 | i[7:0]);
                wr(1'b1, i[7:0]);
                wait_rises(3);
                check(period[7:0], per_table[i * 8 +: 8]);
                prev = i[7:0];
            end
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        t_flags;
        t_pins;
        t_sources;
        report_and_stop;
    end
endmodule // testbench
